/* tb.sv */
/*
 self-checking bench: reset values, field writes, refused accesses, selection.
 assumes vfc_host_model as the only bus master.
*/
`timescale 1ns/1ps
module tb
   import vfc_pkg::*;
;
   // value is arbitrary
   localparam logic [7:0] REV = 8'hC3;
   localparam logic [7:0] RV [0:17] = '{REV, 8'h69, 8'hD0, 8'h48, 8'h80, 8'h80, 8'h80,
      8'h80, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h80, 8'h20, 8'h40, 8'h40, 8'h00};
   logic sys_clk_i;
   logic rstn_i;
   logic scl;
   logic host_oe;
   logic dut_oe;
   logic dut_sda;
   wire logic sda_w;
   logic [3:0] auto_in;
   logic [11:0] pll_div;
   logic [1:0] rng;
   logic [2:0] pump;
   logic ext;
   logic [4:0] phase;
   logic [7:0] gain [0:2];
   logic [7:0] trim [0:2];
   logic [7:0] tgt [0:2];
   logic [7:0] sep;
   logic [5:0] enter_lv;
   logic [5:0] exit_lv;
   logic [3:0] selv;
   int bad_count = 0;
   int checks = 0;

   // pull-up: an unknown enable stays unknown on the wire
   assign sda_w = host_oe ? 1'b0 : dut_oe ? dut_sda : 1'b1;

   vfc_host_model host (.sys_clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl),
      .sda_oe_o(host_oe));

   vfc_regs #(.DEV_ADDR(7'h4C), .SILICON_REV(REV)) DUT (.sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_w), .sda_o(dut_sda), .sda_oe_o(dut_oe),
      .auto_hsync_green_i(auto_in[3]), .auto_vsync_green_i(auto_in[2]),
      .auto_channel_i(auto_in[1]), .auto_digital_if_i(auto_in[0]),
      .pll_divider_o(pll_div), .pll_oscillator_range_o(rng), .charge_pump_o(pump),
      .ext_clk_sel_o(ext), .sample_phase_o(phase), .red_gain_o(gain[0]),
      .green_gain_o(gain[1]), .blue_gain_o(gain[2]), .red_trim_o(trim[0]),
      .green_trim_o(trim[1]), .blue_trim_o(trim[2]), .red_target_o(tgt[0]),
      .green_target_o(tgt[1]), .blue_target_o(tgt[2]), .sync_sep_width_o(sep),
      .green_sync_enter_o(enter_lv), .green_sync_exit_o(exit_lv),
      .hsync_from_green_o(selv[3]), .vsync_from_green_o(selv[2]),
      .channel_sel_o(selv[1]), .digital_if_sel_o(selv[0]));

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // enter level kept at or below exit level, as the host must
   function automatic logic [7:0] pat(input int a, input logic [7:0] x);
      if (a == 15)
         return x[0] ? 8'hFF : 8'h1F;
      if (a == 16)
         return x[0] ? 8'hFF : 8'hFE;
      return 8'(a * 11) ^ 8'h5A ^ x;
   endfunction

   function automatic logic [7:0] msk(input int a);
      case (a)
         2: return 8'hF0;
         3, 15, 16: return 8'hFC;
         4: return 8'hF8;
         default: return 8'hFF;
      endcase
   endfunction

   task automatic t_reset();
      host.rd(A_REV, 18);
      for (int a = 0; a < 18; a++)
         chk("reset value", RV[a], host.q[a]);
      chk("divider", 12'h69D, pll_div);
      chk("range pump ext", 6'b01_001_0, {rng, pump, ext});
      chk("phase", 5'h10, phase);
      chk("selection", 4'h0, selv);
      $display("test reset done");
   endtask

   task automatic t_fields(input logic [7:0] x);
      logic [7:0] pv [0:16];
      for (int a = 0; a < 17; a++)
      begin
         pv[a] = pat(a, x);
         host.d[a] = pv[a];
      end
      host.wr(7'h4C, A_REV, 17);
      chk("write acks", 16'h0001, host.ack_all);
      chk("divider", {pv[1], pv[2][7:4]}, pll_div);
      chk("range", pv[3][7:6], rng);
      chk("pump", pv[3][5:3], pump);
      chk("ext clock", pv[3][2], ext);
      chk("phase", pv[4][7:3], phase);
      for (int j = 0; j < 3; j++)
      begin
         chk("gain", pv[5 + j], gain[j]);
         chk("target", pv[9 + 2 * j], tgt[j]);
         chk("trim", pv[8 + 2 * j], trim[j]);
      end
      chk("separator", pv[14], sep);
      chk("enter", pv[15][7:2], enter_lv);
      chk("exit", pv[16][7:2], exit_lv);
      host.rd(A_REV, 17);
      for (int a = 0; a < 17; a++)
         chk("readback", a == 0 ? REV : pv[a] & msk(a), host.q[a]);
      $display("test fields %h done", x);
   endtask

   task automatic t_refused();
      host.d[0] = 8'h77;
      host.wr(7'h4D, A_R_GAIN, 1);
      chk("foreign address ack", 16'h0000, host.ack_all);
      chk("gain kept", pat(5, 8'hFF), gain[0]);
      host.wr(7'h4C, 8'h12, 1);
      host.rd(8'h12, 1);
      chk("unmapped read", 16'h0000, host.q[0]);
      $display("test refused done");
   endtask

   task automatic t_select();
      logic [7:0] r;
      logic [3:0] ovr;
      for (int k = 0; k < 16; k++)
      begin
         for (int j = 0; j < 4; j++)
         begin
            ovr[j] = k[(j + 1) % 4];
            r[2 * j + 1] = k[j];
            r[2 * j] = ovr[j];
         end
         host.d[0] = r;
         host.wr(7'h4C, A_SRC, 1);
         for (int a = 0; a < 2; a++)
         begin
            @(posedge sys_clk_i);
            #1;
            auto_in = a ? 4'(k) : ~4'(k);
            repeat (3) @(posedge sys_clk_i);
            #1;
            for (int j = 0; j < 4; j++)
               chk("selection", ovr[j] ? r[2 * j + 1] : auto_in[j], selv[j]);
         end
      end
      host.rd(A_SRC, 1);
      chk("select readback", r, host.q[0]);
      $display("test select done");
   endtask

   initial
   begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end

   initial
   begin
      repeat (100000) @(posedge sys_clk_i);
      bad_count++;
      $display("[ERR] run length expected finish seen timeout");
      test_done();
   end

   initial
   begin
      rstn_i = 1'b0;
      auto_in = 4'h0;
      repeat (20) @(posedge sys_clk_i);
      #1;
      rstn_i = 1'b1;
      repeat (10) @(posedge sys_clk_i);
      #1;
      t_reset();
      t_fields(8'h00);
      t_fields(8'hFF);
      t_refused();
      t_select();
      test_done();
   end
endmodule // tb

/* vfc_host_model.sv */
/*
 behavioural 2-wire bus controller that configures and reads the control bank.
 assumes the testbench resolves the data wire with a pull-up.
*/
`timescale 1ns/1ps
module vfc_host_model
(
   input wire logic sys_clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   logic [7:0] d [0:31];
   logic [7:0] q [0:31];
   logic ack_all;

   initial
   begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
      ack_all = 1'b1;
   end

   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask

   // data moves 4 clocks after the clock falls so no edge is seen as a start or stop
   task automatic start();
      wt(4);
      sda_oe_o = 1'b0;
      wt(10);
      scl_o = 1'b1;
      wt(10);
      sda_oe_o = 1'b1;
      wt(10);
      scl_o = 1'b0;
   endtask

   task automatic stop();
      wt(4);
      sda_oe_o = 1'b1;
      wt(10);
      scl_o = 1'b1;
      wt(10);
      sda_oe_o = 1'b0;
      wt(10);
   endtask

   task automatic put(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         wt(4);
         sda_oe_o = ~b[i];
         wt(10);
         scl_o = 1'b1;
         wt(10);
         scl_o = 1'b0;
      end
      wt(4);
      sda_oe_o = 1'b0;
      wt(10);
      scl_o = 1'b1;
      wt(10);
      if (sda_i !== 1'b0)
         ack_all = 1'b0;
      scl_o = 1'b0;
   endtask

   task automatic get(output logic [7:0] b, input logic last);
      for (int i = 7; i >= 0; i--)
      begin
         wt(14);
         scl_o = 1'b1;
         wt(10);
         b[i] = sda_i;
         scl_o = 1'b0;
      end
      wt(4);
      sda_oe_o = ~last;
      wt(10);
      scl_o = 1'b1;
      wt(10);
      scl_o = 1'b0;
      wt(4);
      sda_oe_o = 1'b0;
   endtask

   task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input int n);
      ack_all = 1'b1;
      start();
      put({dev, 1'b0});
      put(ptr);
      for (int i = 0; i < n; i++)
         put(d[i]);
      stop();
   endtask

   task automatic rd(input logic [7:0] ptr, input int n);
      ack_all = 1'b1;
      start();
      put({7'h4C, 1'b0});
      put(ptr);
      start();
      put({7'h4C, 1'b1});
      for (int i = 0; i < n; i++)
         get(q[i], i == n - 1);
      stop();
   endtask
endmodule // vfc_host_model

/* vfc_pin_sync.sv */
/*
 two flip-flop synchroniser for one serial bus pin.
 assumes the pin is asynchronous to sys_clk_i.
*/
`timescale 1ns/1ps
module vfc_pin_sync
   import vfc_pkg::*;
#(
   parameter logic RESET_VAL = 1'b1
)
(
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic pin_i,
   output logic level_o
);
   logic meta;

   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         meta <= RESET_VAL;
         level_o <= RESET_VAL;
      end
      else
      begin
         meta <= pin_i;
         level_o <= meta;
      end
   end
endmodule // vfc_pin_sync

/* vfc_pkg.sv */
/*
 video front end control bank: register offsets, field positions, reset values
 and masks. assumes an 8-bit register pointer set by the 2-wire serial port.
*/
// Notes on behaviour
// - divider split: 0x01 high byte, 0x02[7:4] low
// - 0x03 holds pump current and oscillator range
// - 0x03 bit 2 selects external converter clock
// - 0x04 bits 7:3 select sampling phase
// - 0x05 to 0x07 hold amplifier gains
// - 0x09, 0x0B, 0x0D hold offset target codes
// - 0x08, 0x0A, 0x0C hold offset brightness trims
// - 0x0E holds maximum separator sync width
// - 0x11 bits 7:6 pick horizontal sync source
// - 0x11 bits 5:4 pick vertical sync source
// - 0x11 bits 3:2 pick input channel
// - 0x11 bits 1:0 pick analog or digital interface
package vfc_pkg;
   localparam logic [7:0] A_REV = 8'h00;
   localparam logic [7:0] A_DIV_HI = 8'h01;
   localparam logic [7:0] A_DIV_LO = 8'h02;
   localparam logic [7:0] A_PLL = 8'h03;
   localparam logic [7:0] A_PHASE = 8'h04;
   localparam logic [7:0] A_R_GAIN = 8'h05;
   localparam logic [7:0] A_G_GAIN = 8'h06;
   localparam logic [7:0] A_B_GAIN = 8'h07;
   localparam logic [7:0] A_R_TRIM = 8'h08;
   localparam logic [7:0] A_R_TGT = 8'h09;
   localparam logic [7:0] A_G_TRIM = 8'h0A;
   localparam logic [7:0] A_G_TGT = 8'h0B;
   localparam logic [7:0] A_B_TRIM = 8'h0C;
   localparam logic [7:0] A_B_TGT = 8'h0D;
   localparam logic [7:0] A_SEP = 8'h0E;
   localparam logic [7:0] A_ENTER = 8'h0F;
   localparam logic [7:0] A_EXIT = 8'h10;
   localparam logic [7:0] A_SRC = 8'h11;
   localparam int RANGE_MSB = 7;
   localparam int RANGE_LSB = 6;
   localparam int PUMP_MSB = 5;
   localparam int PUMP_LSB = 3;
   localparam int EXTCLK_BIT = 2;
   localparam int PHASE_LSB = 3;
   localparam int LEVEL_LSB = 2;
   localparam int DIVLO_LSB = 4;
   localparam int H_SEL = 7;
   localparam int H_OVR = 6;
   localparam int V_SEL = 5;
   localparam int V_OVR = 4;
   localparam int CH_SEL = 3;
   localparam int CH_OVR = 2;
   localparam int IF_SEL = 1;
   localparam int IF_OVR = 0;
   localparam logic [7:0] RST_DIV_HI = 8'h69;
   localparam logic [7:0] RST_DIV_LO = 8'hD0;
   localparam logic [7:0] RST_PLL = 8'h48;
   localparam logic [7:0] RST_MID = 8'h80;
   localparam logic [7:0] RST_SEP = 8'h20;
   localparam logic [7:0] RST_LEVEL = 8'h40;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] MASK_NIB = 8'hF0;
   localparam logic [7:0] MASK_PLL = 8'hFC;
   localparam logic [7:0] MASK_PHASE = 8'hF8;
   localparam logic [7:0] MASK_FULL = 8'hFF;

   function automatic logic [7:0] vfc_mask(input logic [7:0] a);
      case (a)
         A_DIV_LO: vfc_mask = MASK_NIB;
         A_PLL, A_ENTER, A_EXIT: vfc_mask = MASK_PLL;
         A_PHASE: vfc_mask = MASK_PHASE;
         default: vfc_mask = MASK_FULL;
      endcase
   endfunction

   function automatic logic [7:0] vfc_rstval(input logic [7:0] a);
      case (a)
         A_DIV_HI: vfc_rstval = RST_DIV_HI;
         A_DIV_LO: vfc_rstval = RST_DIV_LO;
         A_PLL: vfc_rstval = RST_PLL;
         A_PHASE, A_R_GAIN, A_G_GAIN, A_B_GAIN: vfc_rstval = RST_MID;
         A_R_TGT, A_G_TGT, A_B_TGT: vfc_rstval = RST_MID;
         A_SEP: vfc_rstval = RST_SEP;
         A_ENTER, A_EXIT: vfc_rstval = RST_LEVEL;
         default: vfc_rstval = RST_ZERO;
      endcase
   endfunction
endpackage

/* vfc_regs.sv */
/*
 video front end control bank with its 2-wire serial slave port.
 assumes an external pull-up on both bus wires and a bus well below sys_clk_i/8.
*/
`timescale 1ns/1ps
module vfc_regs
   import vfc_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h4C,
   // value is arbitrary
   parameter logic [7:0] SILICON_REV = 8'h5A
)
(
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic auto_hsync_green_i,
   input wire logic auto_vsync_green_i,
   input wire logic auto_channel_i,
   input wire logic auto_digital_if_i,
   output logic [11:0] pll_divider_o,
   output logic [1:0] pll_oscillator_range_o,
   output logic [2:0] charge_pump_o,
   output logic ext_clk_sel_o,
   output logic [4:0] sample_phase_o,
   output logic [7:0] red_gain_o,
   output logic [7:0] green_gain_o,
   output logic [7:0] blue_gain_o,
   output logic [7:0] red_trim_o,
   output logic [7:0] green_trim_o,
   output logic [7:0] blue_trim_o,
   output logic [7:0] red_target_o,
   output logic [7:0] green_target_o,
   output logic [7:0] blue_target_o,
   output logic [7:0] sync_sep_width_o,
   output logic [5:0] green_sync_enter_o,
   output logic [5:0] green_sync_exit_o,
   output logic hsync_from_green_o,
   output logic vsync_from_green_o,
   output logic channel_sel_o,
   output logic digital_if_sel_o
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WRITE, ST_ACK_WR, ST_READ, ST_ACK_RD
   } vfc_state_t;

   vfc_state_t state, next_state;
   logic [3:0] cnt, next_cnt;
   logic [7:0] shift, next_shift;
   logic [7:0] tx, next_tx;
   logic [7:0] ptr, next_ptr;
   logic oe, next_oe;
   logic rw, next_rw;
   logic first, next_first;
   logic nack, next_nack;
   logic wr_en, next_wr_en;
   logic [7:0] wr_addr, next_wr_addr;
   logic [7:0] wr_data, next_wr_data;
   logic [7:0] regs [1:17];
   logic scl_s, sda_s, scl_q, sda_q;

   vfc_pin_sync #(.RESET_VAL(1'b1)) u_scl_sync (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .pin_i(scl_i),
      .level_o(scl_s)
   );

   vfc_pin_sync #(.RESET_VAL(1'b1)) u_sda_sync (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .pin_i(sda_i),
      .level_o(sda_s)
   );

   // bus conditions, seen one cycle after the synchronisers
   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
   wire bus_stop = scl_s & scl_q & ~sda_q & sda_s;
   wire addr_match = (shift[7:1] == DEV_ADDR);

   // register pointer decode
   wire rd_mapped = (ptr >= A_DIV_HI) && (ptr <= A_SRC);
   wire [7:0] rd_data = (ptr == A_REV) ? SILICON_REV :
                        rd_mapped ? regs[ptr[4:0]] : 8'h00;
   // the revision word has no storage, so a write there cannot land
   wire wr_hit = wr_en && (wr_addr >= A_DIV_HI) && (wr_addr <= A_SRC);
   wire [7:0] src = regs[A_SRC[4:0]];

   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      next_shift = shift;
      next_tx = tx;
      next_ptr = ptr;
      next_oe = oe;
      next_rw = rw;
      next_first = first;
      next_nack = nack;
      next_wr_en = 1'b0;
      next_wr_addr = wr_addr;
      next_wr_data = wr_data;
      if (bus_start)
      begin
         next_state = ST_ADDR;
         next_cnt = 4'h0;
         next_oe = 1'b0;
      end
      else if (bus_stop)
      begin
         next_state = ST_IDLE;
         next_oe = 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               next_oe = 1'b0;
            end
            ST_ADDR:
            begin
               if (scl_rise)
               begin
                  next_shift = {shift[6:0], sda_s};
                  next_cnt = cnt + 4'h1;
               end
               else if (scl_fall && cnt == 4'h8)
               begin
                  // a foreign address leaves the bus alone until the next start
                  next_state = addr_match ? ST_ACK_ADDR : ST_IDLE;
                  next_oe = addr_match;
                  next_rw = shift[0];
               end
            end
            ST_ACK_ADDR:
            begin
               if (scl_fall)
               begin
                  next_cnt = 4'h0;
                  next_first = 1'b1;
                  if (rw)
                  begin
                     next_tx = rd_data;
                     next_ptr = ptr + 8'h01;
                     next_oe = ~rd_data[7];
                     next_state = ST_READ;
                  end
                  else
                  begin
                     next_oe = 1'b0;
                     next_state = ST_WRITE;
                  end
               end
            end
            ST_WRITE:
            begin
               if (scl_rise)
               begin
                  next_shift = {shift[6:0], sda_s};
                  next_cnt = cnt + 4'h1;
               end
               else if (scl_fall && cnt == 4'h8)
               begin
                  // first byte after the address sets the pointer
                  if (first)
                  begin
                     next_ptr = shift;
                     next_first = 1'b0;
                  end
                  else
                  begin
                     next_wr_en = 1'b1;
                     next_wr_addr = ptr;
                     next_wr_data = shift;
                     next_ptr = ptr + 8'h01;
                  end
                  next_oe = 1'b1;
                  next_state = ST_ACK_WR;
               end
            end
            ST_ACK_WR:
            begin
               if (scl_fall)
               begin
                  next_oe = 1'b0;
                  next_cnt = 4'h0;
                  next_state = ST_WRITE;
               end
            end
            ST_READ:
            begin
               if (scl_fall)
               begin
                  if (cnt == 4'h7)
                  begin
                     next_oe = 1'b0;
                     next_state = ST_ACK_RD;
                  end
                  else
                  begin
                     next_cnt = cnt + 4'h1;
                     next_tx = {tx[6:0], 1'b0};
                     next_oe = ~tx[6];
                  end
               end
            end
            ST_ACK_RD:
            begin
               if (scl_rise)
               begin
                  next_nack = sda_s;
               end
               else if (scl_fall)
               begin
                  next_cnt = 4'h0;
                  if (nack)
                  begin
                     next_state = ST_IDLE;
                     next_oe = 1'b0;
                  end
                  else
                  begin
                     next_tx = rd_data;
                     next_ptr = ptr + 8'h01;
                     next_oe = ~rd_data[7];
                     next_state = ST_READ;
                  end
               end
            end
            default:
            begin
               next_state = ST_IDLE;
               next_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         state <= ST_IDLE;
         cnt <= 4'h0;
         shift <= 8'h00;
         tx <= 8'h00;
         ptr <= 8'h00;
         oe <= 1'b0;
         rw <= 1'b0;
         first <= 1'b0;
         nack <= 1'b0;
         wr_en <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         shift <= next_shift;
         tx <= next_tx;
         ptr <= next_ptr;
         oe <= next_oe;
         rw <= next_rw;
         first <= next_first;
         nack <= next_nack;
         wr_en <= next_wr_en;
         wr_addr <= next_wr_addr;
         wr_data <= next_wr_data;
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   // storing through the mask keeps undefined low bits at zero on readback
   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         for (int i = 1; i <= 17; i++)
         begin
            regs[i] <= vfc_rstval(8'(i));
         end
      end
      else if (wr_hit)
      begin
         regs[wr_addr[4:0]] <= wr_data & vfc_mask(wr_addr);
      end
   end

   // registered source selection, manual bits override the auto inputs
   wire next_hsync = src[H_OVR] ? src[H_SEL] : auto_hsync_green_i;
   wire next_vsync = src[V_OVR] ? src[V_SEL] : auto_vsync_green_i;
   wire next_chan = src[CH_OVR] ? src[CH_SEL] : auto_channel_i;
   wire next_digif = src[IF_OVR] ? src[IF_SEL] : auto_digital_if_i;

   always_ff @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         hsync_from_green_o <= 1'b0;
         vsync_from_green_o <= 1'b0;
         channel_sel_o <= 1'b0;
         digital_if_sel_o <= 1'b0;
      end
      else
      begin
         hsync_from_green_o <= next_hsync;
         vsync_from_green_o <= next_vsync;
         channel_sel_o <= next_chan;
         digital_if_sel_o <= next_digif;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = oe;
   assign pll_divider_o = {regs[A_DIV_HI[4:0]], regs[A_DIV_LO[4:0]][7:DIVLO_LSB]};
   assign pll_oscillator_range_o = regs[A_PLL[4:0]][RANGE_MSB:RANGE_LSB];
   assign charge_pump_o = regs[A_PLL[4:0]][PUMP_MSB:PUMP_LSB];
   assign ext_clk_sel_o = regs[A_PLL[4:0]][EXTCLK_BIT];
   assign sample_phase_o = regs[A_PHASE[4:0]][7:PHASE_LSB];
   assign red_gain_o = regs[A_R_GAIN[4:0]];
   assign green_gain_o = regs[A_G_GAIN[4:0]];
   assign blue_gain_o = regs[A_B_GAIN[4:0]];
   assign red_trim_o = regs[A_R_TRIM[4:0]];
   assign green_trim_o = regs[A_G_TRIM[4:0]];
   assign blue_trim_o = regs[A_B_TRIM[4:0]];
   assign red_target_o = regs[A_R_TGT[4:0]];
   assign green_target_o = regs[A_G_TGT[4:0]];
   assign blue_target_o = regs[A_B_TGT[4:0]];
   assign sync_sep_width_o = regs[A_SEP[4:0]];
   // the enter/exit ordering is left to the host; no clamping here
   assign green_sync_enter_o = regs[A_ENTER[4:0]][7:LEVEL_LSB];
   assign green_sync_exit_o = regs[A_EXIT[4:0]][7:LEVEL_LSB];

   a_div_split: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      wr_en && wr_addr == A_DIV_LO |=> pll_divider_o[3:0] == $past(wr_data[7:4]))
      else $error("divider low nibble not taken");
   a_pump_range: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      wr_en && wr_addr == A_PLL |=> {pll_oscillator_range_o, charge_pump_o} == $past(wr_data[7:3]))
      else $error("pump or range field wrong");
   a_ext_clock: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      wr_en && wr_addr == A_PLL |=> ext_clk_sel_o == $past(wr_data[2]))
      else $error("external clock select wrong");
   a_phase_field: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      wr_en && wr_addr == A_PHASE |=> sample_phase_o == $past(wr_data[7:3]))
      else $error("phase field wrong");
   a_gain_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      wr_en && wr_addr == A_B_GAIN |=> blue_gain_o == $past(wr_data))
      else $error("blue gain not written");
   a_target_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      wr_en && wr_addr == A_G_TGT |=> green_target_o == $past(wr_data))
      else $error("green target not written");
   a_trim_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      wr_en && wr_addr == A_R_TRIM |=> red_trim_o == $past(wr_data))
      else $error("red trim not written");
   a_sep_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      wr_en && wr_addr == A_SEP |=> sync_sep_width_o == $past(wr_data))
      else $error("separator width not written");
   a_hsync_pick: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      ##1 hsync_from_green_o == $past(src[H_OVR] ? src[H_SEL] : auto_hsync_green_i))
      else $error("hsync source selection wrong");
   a_vsync_pick: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      src[V_OVR] && $stable(src) |=> vsync_from_green_o == $past(src[V_SEL]))
      else $error("vsync forced source ignored");
   a_chan_pick: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      !src[CH_OVR] && $stable(src) |=> channel_sel_o == $past(auto_channel_i))
      else $error("auto channel not followed");
   a_if_pick: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      src[IF_OVR] && $stable(src) |=> digital_if_sel_o == $past(src[IF_SEL]))
      else $error("interface forced select ignored");
   a_rev_fixed: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      state == ST_ACK_ADDR && scl_fall && rw && ptr == A_REV |=> tx == SILICON_REV)
      else $error("revision readback changed");
   a_low_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      wr_en && wr_addr == A_PHASE |=> regs[A_PHASE[4:0]][2:0] == 3'h0)
      else $error("unused phase bits not zero");
   a_ack_write: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      next_wr_en |=> oe && state == ST_ACK_WR)
      else $error("data byte not acknowledged");

   c_write_byte: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) wr_hit);
   c_read_more: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
      state == ST_ACK_RD && scl_fall && !nack);
   c_read_end: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
      state == ST_ACK_RD && scl_fall && nack);
   c_manual_src: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
      src[H_OVR] && src[H_SEL]);
endmodule // vfc_regs
